// *** core/cid_defs.svh ***
// Constants for the contact input debounce and time-stamp block.
`ifndef CID_DEFS_SVH
`define CID_DEFS_SVH
// Clock rate in MHz; one microsecond is this many cycles.
`define CID_CLK_MHZ 200
// Scan period in microseconds.
`define CID_TICK_US 500
// Scan period in clock cycles, derived from the two figures above.
`define CID_TICK_CYC (`CID_TICK_US * `CID_CLK_MHZ)
// Clock cycles in one microsecond of the time-stamp counter.
`define CID_US_CYC (1 * `CID_CLK_MHZ)
// Protection passes in each power-system cycle, as a shift.
`define CID_PASS_SHIFT 3
// Register byte offsets.
`define CID_REG_EVT_EN 8'h00
`define CID_REG_SETTLE 8'h04
`define CID_REG_CYCLE 8'h08
`define CID_REG_STATE 8'h0c
`define CID_REG_TIME 8'h10
`define CID_REG_THR0 8'h20
// Reset values.
`define CID_SETTLE_RST 8'h05
`define CID_CYCLE_RST 24'h32dcd5
`define CID_THR_RST 8'h11
`endif

// *** core/cid_pkg.sv ***
// Types shared by the contact input debounce and time-stamp block.
package cid_pkg;
    // One validated change of one input, handed to the event recorder.
    typedef struct packed {
        logic valid;
        logic state;
        logic [31:0] stamp;
    } cid_event_t;
    // Wishbone request from the master.
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } cid_wb_req_t;
    // Wishbone answer from the slave.
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } cid_wb_rsp_t;
endpackage : cid_pkg

// *** core/cid_top.sv ***
// Contact input scanner with debounce, time stamps and pass-aligned operands.
`timescale 1ns/1ps
`include "cid_defs.svh"
module cid_top #(
    parameter int NUM_IN = 8,
    parameter int TICK_CYC = `CID_TICK_CYC
) (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire cid_pkg::cid_wb_req_t wb_req_in,
    output cid_pkg::cid_wb_rsp_t wb_rsp_out,
    input wire logic [NUM_IN-1:0][7:0] volt_in,
    output logic [NUM_IN-1:0] input_closed_operand_out,
    output logic [NUM_IN-1:0] input_open_operand_out,
    output logic pass_start_out,
    output cid_pkg::cid_event_t [NUM_IN-1:0] event_out
);
    import cid_pkg::*;

    localparam int NGRP = NUM_IN / 4;

    // Refuse sizes the group and register layout cannot carry.
    if (NUM_IN < 4 || NUM_IN > 32 || NUM_IN % 4 != 0 || TICK_CYC < 2) begin
        $error("cid_top: NUM_IN must be 4..32 in fours, TICK_CYC >= 2");
    end

    // Two-stage reset release; the rest of the block uses rst_n.
    logic rst_meta_n;
    logic rst_n;
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_meta_n <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n <= rst_meta_n;
        end
    end

    // Software settings.
    logic [31:0] evt_en;
    logic [7:0] settle;
    logic [23:0] cyc_len;
    logic [NGRP-1:0][7:0] thr;
    logic ack;
    logic [31:0] rdat;
    logic [31:0] next_evt_en;
    logic [7:0] next_settle;
    logic [23:0] next_cyc_len;
    logic [NGRP-1:0][7:0] next_thr;
    logic next_ack;
    logic [31:0] next_rdat;
    // Time base and scheduler state.
    logic [31:0] tick_cnt;
    logic tick;
    logic [7:0] us_pre;
    logic [31:0] now_us;
    logic [23:0] pass_cnt;
    logic [23:0] pass_len;
    logic [31:0] next_tick_cnt;
    logic [7:0] next_us_pre;
    logic [31:0] next_now_us;
    logic [23:0] next_pass_cnt;
    // Validated states and their pass-aligned copies.
    logic [NUM_IN-1:0] valid_st;
    logic [NUM_IN-1:0] opnd;
    logic [NUM_IN-1:0] next_opnd;

    // Wishbone register file: decode, write, one-cycle registered answer.
    always_comb begin
        next_evt_en = evt_en;
        next_settle = settle;
        next_cyc_len = cyc_len;
        next_thr = thr;
        next_ack = wb_req_in.cyc && wb_req_in.stb && !ack;
        next_rdat = 32'h0;
        if (next_ack && wb_req_in.we) begin
            // Writes take byte enables; narrow fields use their low lanes.
            for (int b = 0; b < 4; b++) begin
                if (wb_req_in.sel[b] && wb_req_in.adr == `CID_REG_EVT_EN) begin
                    next_evt_en[b*8 +: 8] = wb_req_in.dat[b*8 +: 8];
                end
                if (wb_req_in.sel[b] && wb_req_in.adr == `CID_REG_CYCLE
                        && b < 3) begin
                    next_cyc_len[b*8 +: 8] = wb_req_in.dat[b*8 +: 8];
                end
            end
            if (wb_req_in.sel[0] && wb_req_in.adr == `CID_REG_SETTLE) begin
                next_settle = wb_req_in.dat[7:0];
            end
            for (int g = 0; g < NGRP; g++) begin
                if (wb_req_in.sel[0] && wb_req_in.adr ==
                        8'(`CID_REG_THR0 + 4 * g)) begin
                    next_thr[g] = wb_req_in.dat[7:0];
                end
            end
        end else if (next_ack) begin
            // Reads; unmapped addresses answer with zero.
            unique case (wb_req_in.adr)
                `CID_REG_EVT_EN: next_rdat = evt_en;
                `CID_REG_SETTLE: next_rdat = {24'h0, settle};
                `CID_REG_CYCLE: next_rdat = {8'h0, cyc_len};
                `CID_REG_STATE: next_rdat = 32'(valid_st);
                `CID_REG_TIME: next_rdat = now_us;
                default: begin
                    for (int g = 0; g < NGRP; g++) begin
                        if (wb_req_in.adr == 8'(`CID_REG_THR0 + 4 * g)) begin
                            next_rdat = {24'h0, thr[g]};
                        end
                    end
                end
            endcase
        end
    end

    // Register the settings and the bus answer.
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            evt_en <= 32'h0;
            settle <= `CID_SETTLE_RST;
            cyc_len <= `CID_CYCLE_RST;
            thr <= {NGRP{`CID_THR_RST}};
            ack <= 1'b0;
            rdat <= 32'h0;
        end else begin
            evt_en <= next_evt_en;
            settle <= next_settle;
            cyc_len <= next_cyc_len;
            thr <= next_thr;
            ack <= next_ack;
            rdat <= next_rdat;
        end
    end
    assign wb_rsp_out = '{ack: ack, dat: rdat};

    // Scan tick, microsecond clock and protection pass pacing.
    assign tick = (tick_cnt == 32'(TICK_CYC - 1));
    assign pass_len = cyc_len >> `CID_PASS_SHIFT;
    always_comb begin
        next_tick_cnt = tick ? 32'h0 : tick_cnt + 32'h1;
        next_us_pre = us_pre + 8'h1;
        next_now_us = now_us;
        if (us_pre == 8'(`CID_US_CYC - 1)) begin
            next_us_pre = 8'h0;
            next_now_us = now_us + 32'h1;
        end
        // A pass length below two cycles is held at two.
        next_pass_cnt = pass_cnt + 24'h1;
        if (pass_cnt + 24'h1 >= pass_len && pass_cnt >= 24'h1) begin
            next_pass_cnt = 24'h0;
        end
        // Operands change only as a pass begins.
        next_opnd = (pass_cnt == 24'h0) ? valid_st : opnd;
    end

    // Register the time base and the operands.
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt <= 32'h0;
            us_pre <= 8'h0;
            now_us <= 32'h0;
            pass_cnt <= 24'h1;
            opnd <= '0;
        end else begin
            tick_cnt <= next_tick_cnt;
            us_pre <= next_us_pre;
            now_us <= next_now_us;
            pass_cnt <= next_pass_cnt;
            opnd <= next_opnd;
        end
    end
    assign pass_start_out = (pass_cnt == 24'h0);
    assign input_closed_operand_out = opnd;
    assign input_open_operand_out = ~opnd;

    // One debounce channel per input; both directions share the code.
    for (genvar i = 0; i < NUM_IN; i++) begin : g_in
        logic lvl;
        logic cand;
        logic [8:0] cnt;
        logic [31:0] stamp;
        cid_event_t evt;
        logic next_cand;
        logic [8:0] next_cnt;
        logic [31:0] next_stamp;
        logic next_valid;
        cid_event_t next_evt;
        logic vst; // This channel's validated state, one driver per bit.
        // Closed when the voltage reaches the group threshold.
        assign lvl = (volt_in[i] >= thr[i/4]);
        assign valid_st[i] = vst;
        // Track the candidate run and validate it once long enough.
        always_comb begin
            next_cand = cand;
            next_cnt = cnt;
            next_stamp = stamp;
            next_valid = valid_st[i];
            next_evt = '0;
            if (tick) begin
                if (lvl == valid_st[i]) begin
                    // Excursion ended early: drop the run.
                    next_cand = lvl;
                    next_cnt = 9'h0;
                end else if (lvl != cand || cnt == 9'h0) begin
                    // First sample of a new run stamps the time.
                    next_cand = lvl;
                    next_cnt = 9'h1;
                    next_stamp = now_us;
                end else begin
                    next_cnt = cnt + 9'h1;
                end
                if (lvl != valid_st[i] && next_cnt > {1'b0, settle}) begin
                    // Run is long enough: same test either way.
                    next_valid = lvl;
                    next_cnt = 9'h0;
                    next_evt.valid = evt_en[i];
                    next_evt.state = lvl;
                    next_evt.stamp = next_stamp;
                end
            end
        end

        // Register the channel; reset clears every count.
        always_ff @(posedge clk_sys_in or negedge rst_n) begin
            if (!rst_n) begin
                cand <= 1'b0;
                cnt <= 9'h0;
                stamp <= 32'h0;
                vst <= 1'b0;
                evt <= '0;
            end else begin
                cand <= next_cand;
                cnt <= next_cnt;
                stamp <= next_stamp;
                vst <= next_valid;
                evt <= next_evt;
            end
        end
        assign event_out[i] = evt;
    end

    // Helper count of cycles since the last scan tick.
    logic [31:0] gap;
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            gap <= 32'h0;
        end else begin
            gap <= tick ? 32'h0 : gap + 32'h1;
        end
    end

    // Ticks are exactly one scan period apart.
    property p_tick_period;
        @(posedge clk_sys_in) disable iff (!rst_n)
            tick |-> gap == 32'(TICK_CYC - 1);
    endproperty
    a_tick_period: assert property (p_tick_period)
        else $error("scan tick period wrong");

    // Validated states move only on a scan tick.
    property p_valid_on_tick;
        @(posedge clk_sys_in) disable iff (!rst_n)
            !tick |=> $stable(valid_st);
    endproperty
    a_valid_on_tick: assert property (p_valid_on_tick)
        else $error("validated state changed off tick");

    // Operands move only at the start of a pass.
    property p_opnd_at_pass;
        @(posedge clk_sys_in) disable iff (!rst_n)
            $changed(opnd) |-> $past(pass_start_out);
    endproperty
    a_opnd_at_pass: assert property (p_opnd_at_pass)
        else $error("operand changed outside pass start");

    // At a pass start the operands take the validated states.
    sequence s_pass;
        pass_start_out;
    endsequence
    property p_opnd_follow;
        @(posedge clk_sys_in) disable iff (!rst_n)
            s_pass |=> opnd == $past(valid_st);
    endproperty
    a_opnd_follow: assert property (p_opnd_follow)
        else $error("operand missed validated state");

    // Closed and open operands are always complements.
    property p_open_closed;
        @(posedge clk_sys_in) disable iff (!rst_n)
            input_open_operand_out == ~input_closed_operand_out;
    endproperty
    a_open_closed: assert property (p_open_closed)
        else $error("open and closed operands disagree");

    // No event is logged for input 0 with logging off.
    property p_evt_enable;
        @(posedge clk_sys_in) disable iff (!rst_n)
            event_out[0].valid |-> $past(evt_en[0]);
    endproperty
    a_evt_enable: assert property (p_evt_enable)
        else $error("event logged while disabled");

    // A logged stamp of input 0 is never later than the microsecond clock in the cycle the event is output.
    property p_stamp_early;
        @(posedge clk_sys_in) disable iff (!rst_n)
            event_out[0].valid |-> event_out[0].stamp <= now_us;
    endproperty
    a_stamp_early: assert property (p_stamp_early)
        else $error("event stamp later than validation");

    // On input 0, a sample matching the validated state clears the run count.
    property p_count_clear;
        @(posedge clk_sys_in) disable iff (!rst_n)
            tick && g_in[0].lvl == valid_st[0] |=> g_in[0].cnt == 9'h0;
    endproperty
    a_count_clear: assert property (p_count_clear)
        else $error("run count not restarted");

    // The microsecond clock advances once per microsecond.
    property p_us_step;
        @(posedge clk_sys_in) disable iff (!rst_n)
            us_pre == 8'(`CID_US_CYC - 1) |=> now_us == $past(now_us) + 1;
    endproperty
    a_us_step: assert property (p_us_step)
        else $error("microsecond clock did not step");
endmodule : cid_top

// *** sim/cid_contact_model.sv ***
// Behavioural model of the wetted contact circuits that feed the scanner.
`timescale 1ns/1ps
module cid_contact_model #(
    parameter int NUM_IN = 8
) (
    input wire logic clk_sys_in,
    input wire logic [NUM_IN-1:0] level_in,
    input wire logic [NUM_IN/4-1:0][7:0] thr_in,
    output logic [NUM_IN-1:0][7:0] volt_out
);
    int seed = 38; // Fixed seed for the noise on the contact voltages.
    logic [7:0] r; // Noise drawn for one contact in one cycle.
    // A fresh noisy code each clock, always on the commanded side of the
    // group threshold, so that boundary codes are met by chance.
    always @(posedge clk_sys_in) begin
        for (int i = 0; i < NUM_IN; i++) begin
            r = 8'($random(seed)) & 8'h03;
            if (level_in[i]) begin
                volt_out[i] <= thr_in[i/4] + r;
            end else begin
                volt_out[i] <= thr_in[i/4] - 8'h01 - r;
            end
        end
    end
endmodule // cid_contact_model

// *** sim/contact_input_debounce_timestamp_tb.sv ***
// Self-checking bench for the contact input debounce block.
`timescale 1ns/1ps
`include "cid_defs.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
    bad_count++; $display("[ERR] %0t mismatch %h %h", $time, a, e); end end
module contact_input_debounce_timestamp_tb;
    import cid_pkg::*;
    localparam int N = 8; // Inputs, two groups of four.
    localparam int TK = 100; // Short scan period in clocks.
    typedef struct {int idx; logic st; int us; int at;} cid_note_t;
    logic clk_sys_in = 1'b0;
    logic reset_n_in = 1'b0;
    cid_wb_req_t wb_req_in = '0;
    cid_wb_rsp_t wb_rsp_out;
    logic [N-1:0][7:0] volt_in;
    logic [N-1:0] closed, opened, lvl = '0, st_exp = '0, en = '0;
    logic pass_start_out;
    cid_event_t [N-1:0] event_out;
    logic [1:0][7:0] thr = {8'h11, 8'h11}; // Group thresholds now set.
    int bad_count = 0;
    int checks_done = 0;
    int cyc_n = 0; // Cycles since reset was lifted.
    int settle = 5; // Settle interval now programmed, in ticks.
    int seed = 38;
    int p1, p2;
    logic [31:0] rdq[$]; // Expected read data, oldest first.
    cid_note_t evq[$]; // Expected events, oldest first.
    cid_note_t nt;
    cid_contact_model #(.NUM_IN(N)) model (.clk_sys_in(clk_sys_in),
        .level_in(lvl), .thr_in(thr), .volt_out(volt_in));
    cid_top #(.NUM_IN(N), .TICK_CYC(TK)) dut (.clk_sys_in(clk_sys_in),
        .reset_n_in(reset_n_in), .wb_req_in(wb_req_in),
        .wb_rsp_out(wb_rsp_out), .volt_in(volt_in),
        .input_closed_operand_out(closed), .input_open_operand_out(opened),
        .pass_start_out(pass_start_out), .event_out(event_out));
    // Clock and a free cycle count used to predict stamps and timing.
    always #2.5 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) cyc_n <= reset_n_in ? cyc_n + 1 : 0;
    function automatic logic near(logic signed [31:0] a, b, int t);
        return (a - b <= t) && (b - a <= t);
    endfunction
    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // One classic Wishbone access; a read notes its expected data first.
    task automatic bus(input logic we, input logic [7:0] a,
                       input logic [31:0] d, input logic [31:0] e);
        if (!we) rdq.push_back(e);
        wb_req_in <= '{1'b1, 1'b1, we, a, 4'hf, d};
        do @(posedge clk_sys_in); while (wb_rsp_out.ack !== 1'b1);
        wb_req_in <= '0;
        @(posedge clk_sys_in);
    endtask
    // Waits to the middle of a scan interval, clear of the tick.
    task automatic sync();
        do @(posedge clk_sys_in); while (cyc_n % TK != 50);
    endtask
    // Commands new contact levels and notes every logged change.
    task automatic flip(input logic [N-1:0] nv);
        sync();
        for (int i = 0; i < N; i++) begin
            if (nv[i] != st_exp[i] && en[i]) begin
                evq.push_back('{i, nv[i], (cyc_n + 49) / 200,
                                cyc_n + 52 + settle * TK});
            end
        end
        lvl <= nv;
        st_exp = nv;
    endtask
    // Waits for a pass start and returns the cycle count at its end.
    task automatic waitpass(output int c);
        int n = 0;
        do begin @(posedge clk_sys_in); n++; end
            while (pass_start_out !== 1'b1 && n < 200);
        if (n >= 200) bad_count++;
        c = cyc_n;
    endtask
    // Waits until all noted events came, then checks pass-aligned operands.
    task automatic settle_check();
        int n = 0;
        while (evq.size() > 0 && n < 3000) begin
            @(posedge clk_sys_in);
            n++;
        end
        if (n >= 3000) bad_count++;
        repeat ((settle + 2) * TK) @(posedge clk_sys_in);
        waitpass(n);
        #1;
        `CHK(closed, st_exp)
        `CHK(opened, ~st_exp)
        @(posedge clk_sys_in);
        bus(1'b0, `CID_REG_STATE, 0, {24'h0, st_exp});
    endtask
    // Read data monitor.
    always @(posedge clk_sys_in) begin
        if (wb_rsp_out.ack === 1'b1 && wb_req_in.we === 1'b0) begin
            `CHK(wb_rsp_out.dat, rdq.pop_front())
        end
    end
    // Event monitor: each pulse is matched against the oldest note.
    always @(posedge clk_sys_in) begin
        for (int i = 0; i < N; i++) begin
            if (event_out[i].valid === 1'b1) begin
                if (evq.size() == 0) begin
                    bad_count++;
                    $display("[ERR] %0t unexpected event", $time);
                end else begin
                    nt = evq.pop_front();
                    `CHK(i, nt.idx)
                    `CHK(event_out[i].state, nt.st)
                    `CHK(closed[i], ~nt.st)
                    `CHK(near(event_out[i].stamp, nt.us, 1), 1)
                    `CHK(near(cyc_n, nt.at, 6), 1'b1)
                end
            end
        end
    end
    // Watchdog against a hang.
    initial begin
        repeat (80000) @(posedge clk_sys_in);
        bad_count++;
        tally_and_finish();
    end
    // Main sequence.
    initial begin
        repeat (4) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        repeat (4) @(posedge clk_sys_in);
        `CHK(closed, 8'h00)
        `CHK(opened, 8'hff)
        bus(1'b0, `CID_REG_EVT_EN, 0, 32'h0);
        bus(1'b0, `CID_REG_SETTLE, 0, {24'h0, `CID_SETTLE_RST});
        bus(1'b0, `CID_REG_CYCLE, 0, {8'h0, `CID_CYCLE_RST});
        bus(1'b0, `CID_REG_THR0 + 8'h04, 0, {24'h0, `CID_THR_RST});
        bus(1'b0, 8'h80, 0, 32'h0);
        // Pass length follows the programmed power-cycle length.
        for (int k = 1; k < 3; k++) begin
            bus(1'b1, `CID_REG_CYCLE, 32'd128 / k, 0);
            waitpass(p1);
            waitpass(p1);
            waitpass(p2);
            `CHK(p2 - p1, 16 / k)
        end
        en = 8'hff;
        bus(1'b1, `CID_REG_EVT_EN, 32'hff, 0);
        // Both edges under each pair of recommended group thresholds.
        for (int k = 0; k < 2; k++) begin
            thr = k ? {8'd166, 8'd33} : {8'd84, 8'd17};
            bus(1'b1, `CID_REG_THR0, {24'h0, thr[0]}, 0);
            bus(1'b1, `CID_REG_THR0 + 8'h04, {24'h0, thr[1]}, 0);
            flip(8'hff);
            settle_check();
            flip(8'h00);
            settle_check();
        end
        // Short excursion, then a restarted run with a shorter interval.
        settle = 2;
        bus(1'b1, `CID_REG_SETTLE, 32'h2, 0);
        sync();
        lvl[3] <= 1'b1;
        sync();
        sync();
        lvl[3] <= 1'b0;
        flip(8'h08);
        settle_check();
        // Logging off for input 0: state still moves, no event.
        en = 8'hfe;
        bus(1'b1, `CID_REG_EVT_EN, 32'hfe, 0);
        flip(8'h09);
        settle_check();
        // Read-only and unmapped places ignore writes.
        bus(1'b1, `CID_REG_STATE, 32'hff, 0);
        bus(1'b1, 8'h80, 32'hff, 0);
        bus(1'b0, 8'h80, 0, 32'h0);
        bus(1'b0, `CID_REG_STATE, 0, {24'h0, st_exp});
        // The time register counts microseconds from reset release.
        sync();
        bus(1'b0, `CID_REG_TIME, 0, (cyc_n - 1) / 200);
        // Random contact patterns.
        for (int k = 0; k < 6; k++) begin
            flip(8'($random(seed)));
            settle_check();
        end
        tally_and_finish();
    end
endmodule // contact_input_debounce_timestamp_tb
